// *** pcs_pkg.sv ***
// Offsets, fields, fixed values and carriers
// Functional notes
// - All command bits zero: config access only
// - Status reads live; write one clears
// - I/O space bit reads zero, never claimed
// - Memory bit gates memory access response
// - Master bit zero blocks bus initiation
// - Unsupported command bits read constant zero
// - Parity response bit gates parity action
// - System error bit gates error pin
// - Reset clears writable command bits
// - Unsupported status bits read constant zero
// - Back-to-back target capable reads one
// - Select timing reads medium, target obeys
// - Master parity flag needs response enabled
// - Received target abort sets flag
// - Master abort sets flag, not special
// - System error flag sets even if disabled
// - Any parity error sets detected flag
// - Revision and class code read fixed
// - Header type 80h, self-test zero
// - Latency timer writable, cleared by reset
// - Cache line size filtered, selects multiple
package pcs_pkg;

    // Byte addresses of the configuration words
    localparam logic [7:0] OFS_COMMAND_STATUS = 8'h04;
    localparam logic [7:0] OFS_REV_CLASS      = 8'h08;
    localparam logic [7:0] OFS_CACHE_LAT_HDR  = 8'h0C;

    // Command half-word bit positions
    localparam int B_IO_SPACE   = 0;
    localparam int B_MEM_SPACE  = 1;
    localparam int B_BUS_MASTER = 2;
    localparam int B_PARITY_RSP = 6;
    localparam int B_SYS_ERR    = 8;

    // Status half-word bit positions
    localparam int B_B2B_TARGET = 23;
    localparam int B_PAR_REPORT = 24;
    localparam int B_SEL_TIME0  = 25;
    localparam int B_TARGET_ABORT_SIGNALLED_RCV   = 28;
    localparam int B_MASTER_ABORT_RECEIVED_RCV   = 29;
    localparam int B_SERR_SIG   = 30;
    localparam int B_PAR_DETECT = 31;

    // Reset values of the writable fields
    localparam logic [3:0] CMD_RESET   = 4'h0;
    localparam logic [4:0] FLAG_RESET  = 5'h00;
    localparam logic [7:0] CLS_RESET   = 8'h00;
    localparam logic [7:0] LAT_RESET   = 8'h00;

    // Fixed read-only values
    localparam logic [7:0] CLASS_IFACE = 8'h00;
    localparam logic [7:0] CLASS_SUB   = 8'h80;
    localparam logic [7:0] CLASS_BASE  = 8'h02;
    localparam logic [7:0] HEADER_TYPE = 8'h80;
    localparam logic [7:0] SELF_TEST   = 8'h00;
    localparam logic [1:0] SEL_TIMING  = 2'h1;

    // Valid cache line sizes in dwords
    localparam logic [7:0] CLS_4  = 8'h04;
    localparam logic [7:0] CLS_8  = 8'h08;
    localparam logic [7:0] CLS_16 = 8'h10;
    localparam logic [7:0] CLS_32 = 8'h20;
    localparam logic [7:0] CLS_64 = 8'h40;
    localparam logic [7:0] CLS_NONE = 8'h00;

    // Configuration access request from the target front end
    typedef struct packed {
        logic        sel;
        logic        we;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pcs_cfg_req_t;

    // Bus events reported by master and target logic
    typedef struct packed {
        logic target_abort_signalled_rcv;
        logic master_abort_received_rcv;
        logic special_cyc;
        logic serr_req;
        logic par_det;
        logic master_act;
        logic perr_drive;
    } pcs_evt_t;

    // Device select sequencer states
    typedef enum logic [3:0] {
        DS_IDLE = 4'b0001,
        DS_WAIT = 4'b0010,
        DS_ACT  = 4'b0100,
        DS_TURN = 4'b1000
    } pcs_ds_state_t;

endpackage : pcs_pkg

// *** pcs_devsel.sv ***
// Medium-timing device select driver for the target path
`timescale 1ns/1ps
module pcs_devsel (
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic addr_phase,
    input  wire logic addr_hit,
    input  wire logic claim_en,
    input  wire logic xfer_done,
    output logic      device_select_pin_n_o,
    output logic      device_select_pin_n_oe
);

    pcs_pkg::pcs_ds_state_t state_r;
    pcs_pkg::pcs_ds_state_t state_nxt;

    wire claim = addr_phase & addr_hit & claim_en;

    // One idle clock after the address phase gives medium decode
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pcs_pkg::DS_IDLE: if (claim) state_nxt = pcs_pkg::DS_WAIT;
            pcs_pkg::DS_WAIT: state_nxt = pcs_pkg::DS_ACT;
            pcs_pkg::DS_ACT:  if (xfer_done) state_nxt = pcs_pkg::DS_TURN;
            pcs_pkg::DS_TURN: state_nxt = pcs_pkg::DS_IDLE;
            default:          state_nxt = pcs_pkg::DS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= pcs_pkg::DS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Driven high for one clock before release, so the shared line
    // is never left floating low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            device_select_pin_n_o  <= 1'b1;
            device_select_pin_n_oe <= 1'b0;
        end else begin
            device_select_pin_n_o  <= (state_nxt != pcs_pkg::DS_ACT);
            device_select_pin_n_oe <= (state_nxt == pcs_pkg::DS_ACT) |
                                      (state_nxt == pcs_pkg::DS_TURN);
        end
    end

endmodule : pcs_devsel

// *** pcs_config_regs.sv ***
// Command/status, class and cache/latency configuration words of function 0
`timescale 1ns/1ps
module pcs_config_regs #(
    // Revision code, value arbitrary
    parameter logic [7:0] REVISION_ID = 8'h00
) (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire pcs_pkg::pcs_cfg_req_t cfg_req,
    output logic [31:0]                cfg_rdata,
    output logic                       cfg_done,
    input  wire pcs_pkg::pcs_evt_t     evt,
    input  wire logic                  parity_error_pin_n_i,
    output logic                       parity_error_pin_n_o,
    output logic                       parity_error_pin_n_oe,
    output logic                       system_error_pin_n_o,
    output logic                       system_error_pin_n_oe,
    input  wire logic                  addr_phase,
    input  wire logic                  mem_addr_hit,
    input  wire logic                  io_addr_hit,
    input  wire logic                  xfer_done,
    output logic                       device_select_pin_n_o,
    output logic                       device_select_pin_n_oe,
    input  wire logic                  master_req_in,
    output logic                       master_req_out,
    output logic                       mem_claim_en,
    output logic                       parity_act_en,
    input  wire logic [7:0]            burst_dwords,
    output logic                       use_read_multiple,
    output logic [7:0]                 cache_line_eff,
    output logic [7:0]                 latency_timer
);

    // Writable command bits
    logic       mem_space_control_r;
    logic       bus_master_control_r;
    logic       parity_response_control_r;
    logic       system_error_control_r;
    // Sticky status flags
    logic       data_parity_reported_r;
    logic       target_abort_received_r;
    logic       master_abort_received_r;
    logic       system_error_signalled_r;
    logic       parity_error_detected_r;
    // Cache line and latency bytes
    logic [7:0] cache_line_r;
    logic [7:0] latency_r;
    // Parity pin sampler
    logic       perr_s1_r;
    logic       perr_s2_r;
    logic       perr_s3_r;
    logic       perr_seen_r;

    // Access decode
    wire hit_cmd = cfg_req.sel & (cfg_req.addr[7:2] ==
                   pcs_pkg::OFS_COMMAND_STATUS[7:2]);
    wire hit_rev = cfg_req.sel & (cfg_req.addr[7:2] ==
                   pcs_pkg::OFS_REV_CLASS[7:2]);
    wire hit_clh = cfg_req.sel & (cfg_req.addr[7:2] ==
                   pcs_pkg::OFS_CACHE_LAT_HDR[7:2]);
    wire wr_cmd  = hit_cmd & cfg_req.we;
    wire wr_clh  = hit_clh & cfg_req.we;
    wire wr_b0   = wr_cmd & cfg_req.be[0];
    wire wr_b1   = wr_cmd & cfg_req.be[1];
    wire wr_b2   = wr_cmd & cfg_req.be[2];
    wire wr_b3   = wr_cmd & cfg_req.be[3];

    // Pin sample counts only once the two later stages agree
    wire perr_stable   = (perr_s2_r == perr_s3_r);
    wire perr_pin_low  = ~perr_seen_r;

    // Parity events: own detection, or another agent reporting ours
    wire par_any       = evt.par_det |
                         (evt.master_act & perr_pin_low);
    wire par_master    = evt.master_act &
                         (evt.par_det | evt.perr_drive | perr_pin_low);

    // Flag set terms
    wire set_par_rep   = par_master & parity_response_control_r;
    wire set_target_abort_signalled      = evt.target_abort_signalled_rcv;
    wire set_master_abort_received      = evt.master_abort_received_rcv & ~evt.special_cyc;
    wire set_serr      = evt.serr_req;
    wire set_par_det   = par_any;

    // Write-one clear terms, per byte lane
    wire clr_par_rep   = wr_b3 & cfg_req.wdata[pcs_pkg::B_PAR_REPORT];
    wire clr_target_abort_signalled      = wr_b3 & cfg_req.wdata[pcs_pkg::B_TARGET_ABORT_SIGNALLED_RCV];
    wire clr_master_abort_received      = wr_b3 & cfg_req.wdata[pcs_pkg::B_MASTER_ABORT_RECEIVED_RCV];
    wire clr_serr      = wr_b3 & cfg_req.wdata[pcs_pkg::B_SERR_SIG];
    wire clr_par_det   = wr_b3 & cfg_req.wdata[pcs_pkg::B_PAR_DETECT];

    // Set wins over clear; a write never sets a flag
    wire par_rep_nxt   = (data_parity_reported_r & ~clr_par_rep) |
                         set_par_rep;
    wire target_abort_signalled_nxt      = (target_abort_received_r & ~clr_target_abort_signalled) |
                         set_target_abort_signalled;
    wire master_abort_received_nxt      = (master_abort_received_r & ~clr_master_abort_received) |
                         set_master_abort_received;
    wire serr_nxt      = (system_error_signalled_r & ~clr_serr) |
                         set_serr;
    wire par_det_nxt   = (parity_error_detected_r & ~clr_par_det) |
                         set_par_det;

    // Command half-word; fixed-zero bits never take write data
    wire [15:0] cmd_word;
    assign cmd_word = {7'h00,
                       system_error_control_r,
                       1'b0,
                       parity_response_control_r,
                       3'h0,
                       bus_master_control_r,
                       mem_space_control_r,
                       1'b0};

    // Status half-word; unsupported bits tied, capability bits fixed
    wire [15:0] stat_word;
    assign stat_word = {parity_error_detected_r,
                        system_error_signalled_r,
                        master_abort_received_r,
                        target_abort_received_r,
                        1'b0,
                        pcs_pkg::SEL_TIMING,
                        data_parity_reported_r,
                        1'b1,
                        7'h00};

    wire [31:0] rev_word = {pcs_pkg::CLASS_BASE, pcs_pkg::CLASS_SUB,
                            pcs_pkg::CLASS_IFACE, REVISION_ID};
    wire [31:0] clh_word = {pcs_pkg::SELF_TEST, pcs_pkg::HEADER_TYPE,
                            latency_r, cache_line_r};

    // Read selection; unmapped words read zero
    wire [31:0] rd_sel = hit_cmd ? {stat_word, cmd_word} :
                         hit_rev ? rev_word :
                         hit_clh ? clh_word : 32'h0000_0000;

    // Whole command half-word zero leaves only config access alive
    wire disconnected = (cmd_word == 16'h0000);

    // Command register; reset forces every writable enable low
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {system_error_control_r, parity_response_control_r,
             bus_master_control_r, mem_space_control_r} <=
                pcs_pkg::CMD_RESET;
        end else begin
            if (wr_b0) begin
                mem_space_control_r       <=
                    cfg_req.wdata[pcs_pkg::B_MEM_SPACE];
                bus_master_control_r      <=
                    cfg_req.wdata[pcs_pkg::B_BUS_MASTER];
                parity_response_control_r <=
                    cfg_req.wdata[pcs_pkg::B_PARITY_RSP];
            end
            if (wr_b1) begin
                system_error_control_r    <=
                    cfg_req.wdata[pcs_pkg::B_SYS_ERR];
            end
        end
    end

    // Status flags; the lanes for bits 16 to 23 hold nothing writable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {data_parity_reported_r, target_abort_received_r,
             master_abort_received_r, system_error_signalled_r,
             parity_error_detected_r} <= pcs_pkg::FLAG_RESET;
        end else begin
            data_parity_reported_r   <= par_rep_nxt;
            target_abort_received_r  <= target_abort_signalled_nxt;
            master_abort_received_r  <= master_abort_received_nxt;
            system_error_signalled_r <= serr_nxt;
            parity_error_detected_r  <= par_det_nxt;
        end
    end

    // Cache line and latency bytes, zero after reset
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cache_line_r <= pcs_pkg::CLS_RESET;
            latency_r    <= pcs_pkg::LAT_RESET;
        end else begin
            if (wr_clh & cfg_req.be[0]) begin
                cache_line_r <= cfg_req.wdata[7:0];
            end
            if (wr_clh & cfg_req.be[1]) begin
                latency_r    <= cfg_req.wdata[15:8];
            end
        end
    end

    // Registered read data and a one-cycle completion
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_done  <= 1'b0;
        end else begin
            cfg_rdata <= (cfg_req.sel & ~cfg_req.we) ? rd_sel : cfg_rdata;
            cfg_done  <= cfg_req.sel;
        end
    end

    // Parity pin sampler; stage one feeds stage two only
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            perr_s1_r   <= 1'b1;
            perr_s2_r   <= 1'b1;
            perr_s3_r   <= 1'b1;
            perr_seen_r <= 1'b1;
        end else begin
            perr_s1_r <= parity_error_pin_n_i;
            perr_s2_r <= perr_s1_r;
            perr_s3_r <= perr_s2_r;
            if (perr_stable) begin
                perr_seen_r <= perr_s3_r;
            end
        end
    end

    // Pin drivers: parity pin only when responding, error pin only
    // when enabled; the flag above records errors either way
    wire perr_drive_en = evt.perr_drive & parity_response_control_r;
    wire serr_drive_en = evt.serr_req & system_error_control_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            parity_error_pin_n_o  <= 1'b1;
            parity_error_pin_n_oe <= 1'b0;
            system_error_pin_n_o  <= 1'b1;
            system_error_pin_n_oe <= 1'b0;
        end else begin
            parity_error_pin_n_o  <= ~perr_drive_en;
            parity_error_pin_n_oe <= perr_drive_en | ~parity_error_pin_n_o;
            system_error_pin_n_o  <= ~serr_drive_en;
            system_error_pin_n_oe <= serr_drive_en;
        end
    end

    // Cache line size: unlisted settings behave as zero
    wire cls_valid = (cache_line_r == pcs_pkg::CLS_4)  |
                     (cache_line_r == pcs_pkg::CLS_8)  |
                     (cache_line_r == pcs_pkg::CLS_16) |
                     (cache_line_r == pcs_pkg::CLS_32) |
                     (cache_line_r == pcs_pkg::CLS_64);
    wire [7:0] cls_eff = cls_valid ? cache_line_r : pcs_pkg::CLS_NONE;

    // Long read bursts switch to memory read multiple
    wire mrm_sel = (burst_dwords > cls_eff);

    // Memory claim gated by its enable and by disconnect; I/O never
    wire claim_mem = mem_space_control_r & ~disconnected;
    wire claim_any = mem_addr_hit & ~io_addr_hit;

    pcs_devsel u_devsel (
        .ref_clk,
        .nrst,
        .addr_phase,
        .addr_hit               (claim_any),
        .claim_en               (claim_mem),
        .xfer_done,
        .device_select_pin_n_o,
        .device_select_pin_n_oe
    );

    // Enables toward the bus logic
    assign master_req_out    = master_req_in & bus_master_control_r;
    assign mem_claim_en      = claim_mem;
    assign parity_act_en     = parity_response_control_r;
    assign use_read_multiple = mrm_sel;
    assign cache_line_eff    = cls_eff;
    assign latency_timer     = latency_r;

endmodule : pcs_config_regs

// *** pcs_config_regs_properties.sv ***
// Checker of configuration readback, gating and target pin timing
`timescale 1ns/1ps
module pcs_config_regs_checker #(
    parameter logic [7:0] REVISION_ID = 8'h00
) (
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire pcs_pkg::pcs_cfg_req_t cfg_req,
    input wire logic [31:0]           cfg_rdata,
    input wire pcs_pkg::pcs_evt_t     evt,
    input wire logic                  parity_error_pin_n_o,
    input wire logic                  parity_error_pin_n_oe,
    input wire logic                  system_error_pin_n_o,
    input wire logic                  system_error_pin_n_oe,
    input wire logic                  addr_phase,
    input wire logic                  mem_addr_hit,
    input wire logic                  io_addr_hit,
    input wire logic                  xfer_done,
    input wire logic                  device_select_pin_n_o,
    input wire logic                  device_select_pin_n_oe,
    input wire logic                  master_req_in,
    input wire logic                  master_req_out,
    input wire logic                  mem_claim_en,
    input wire logic                  parity_act_en,
    input wire logic [7:0]            burst_dwords,
    input wire logic                  use_read_multiple,
    input wire logic [7:0]            cache_line_eff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    // Read request and word index
    wire logic       rd_any = cfg_req.sel & ~cfg_req.we;
    wire logic [5:0] wa     = cfg_req.addr[7:2];
    wire logic       ds_idle = ~device_select_pin_n_oe;

    AST_CMD_FIXED: assert property ($past(rd_any && wa == 6'h01) |->
        (cfg_rdata & 32'h0EFF_FEB9) == 32'h0280_0000)
        else $error("fixed bits wrong");
    AST_CLASS: assert property ($past(rd_any && wa == 6'h02) |->
        cfg_rdata == {24'h028000, REVISION_ID})
        else $error("class word wrong");
    AST_HDR: assert property ($past(rd_any && wa == 6'h03) |->
        cfg_rdata[31:16] == 16'h0080)
        else $error("header word wrong");
    AST_MASTER_GATE: assert property ($past(rd_any && wa == 6'h01) |->
        master_req_out == (master_req_in & cfg_rdata[2]))
        else $error("master gate wrong");
    AST_ENABLES: assert property ($past(rd_any && wa == 6'h01) |->
        mem_claim_en == cfg_rdata[1] && parity_act_en == cfg_rdata[6])
        else $error("enable mismatch");
    AST_CACHE: assert property (use_read_multiple ==
        (burst_dwords > cache_line_eff) && cache_line_eff inside
        {8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40})
        else $error("cache filter wrong");
    AST_SERR_PIN: assert property (system_error_pin_n_oe |->
        $past(evt.serr_req) && !system_error_pin_n_o)
        else $error("error pin wrong");
    AST_PERR_PIN: assert property (!parity_error_pin_n_o |->
        parity_error_pin_n_oe && $past(evt.perr_drive && parity_act_en))
        else $error("parity pin wrong");
    AST_DEVSEL_MED: assert property (addr_phase && mem_addr_hit &&
        !io_addr_hit && mem_claim_en && ds_idle && !xfer_done |=>
        device_select_pin_n_o ##1 !device_select_pin_n_o &&
        device_select_pin_n_oe)
        else $error("select timing wrong");
    AST_NO_CLAIM: assert property (addr_phase && ds_idle &&
        (io_addr_hit || !mem_claim_en) |-> ##2 ds_idle)
        else $error("false claim");
    AST_DEVSEL_REL: assert property (xfer_done &&
        !device_select_pin_n_o |=> device_select_pin_n_o &&
        device_select_pin_n_oe ##1 ds_idle)
        else $error("select release wrong");

    // Main scenarios reached
    cover property (cfg_req.sel && cfg_req.we && cfg_req.be[3]);
    cover property (!device_select_pin_n_o);
    cover property (system_error_pin_n_oe);
endmodule : pcs_config_regs_checker

bind pcs_config_regs pcs_config_regs_checker #(
    .REVISION_ID(REVISION_ID)) u_pcs_config_regs_checker (
    .ref_clk, .nrst, .cfg_req, .cfg_rdata, .evt, .parity_error_pin_n_o,
    .parity_error_pin_n_oe, .system_error_pin_n_o, .system_error_pin_n_oe,
    .addr_phase, .mem_addr_hit, .io_addr_hit, .xfer_done,
    .device_select_pin_n_o, .device_select_pin_n_oe, .master_req_in,
    .master_req_out, .mem_claim_en, .parity_act_en, .burst_dwords,
    .use_read_multiple, .cache_line_eff);

// *** pcs_pci_agent.sv ***
// Other bus agent sharing the pulled-up parity error line
`timescale 1ns/1ps
module pcs_pci_agent (
    input  wire logic pull_low,
    input  wire logic dev_o,
    input  wire logic dev_oe,
    output logic      pin_n
);
    // Pull-up idles high; any agent driving low wins the wire
    assign pin_n = ~(pull_low | (dev_oe & ~dev_o));
endmodule : pcs_pci_agent

// *** pcs_config_regs_tb_top.sv ***
// Self-checking bench of the function 0 configuration words
`timescale 1ns/1ps
module pcs_config_regs_tb_top;
    localparam logic [7:0] REV = 8'h5A; // Arbitrary revision code
    logic ref_clk, nrst, ap, mhit, ihit, xd, mreq, pull, d_o, d_oe;
    logic perr_o, perr_oe, serr_o, serr_oe, ds_o, ds_oe, mreq_o, claim;
    logic pact, urm, done, line_n;
    logic [7:0] burst, cls_eff, lat;
    logic [15:0] lfsr_r;
    logic [31:0] rdata, rd, cmd_m, flg_m, d;
    pcs_pkg::pcs_cfg_req_t req;
    pcs_pkg::pcs_evt_t     evt;
    int fails, checked;
    logic [7:0] cls_tab [9] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
                                8'h00, 8'h03, 8'h41, 8'hFF};

    pcs_config_regs #(.REVISION_ID(REV)) u_pcs_config_regs (
        .ref_clk(ref_clk), .nrst(nrst), .cfg_req(req),
        .cfg_rdata(rdata), .cfg_done(done), .evt(evt),
        .parity_error_pin_n_i(line_n), .parity_error_pin_n_o(perr_o),
        .parity_error_pin_n_oe(perr_oe), .system_error_pin_n_o(serr_o),
        .system_error_pin_n_oe(serr_oe), .addr_phase(ap),
        .mem_addr_hit(mhit), .io_addr_hit(ihit), .xfer_done(xd),
        .device_select_pin_n_o(ds_o), .device_select_pin_n_oe(ds_oe),
        .master_req_in(mreq), .master_req_out(mreq_o),
        .mem_claim_en(claim), .parity_act_en(pact), .burst_dwords(burst),
        .use_read_multiple(urm), .cache_line_eff(cls_eff),
        .latency_timer(lat));
    pcs_pci_agent u_pcs_pci_agent (.pull_low(pull), .dev_o(perr_o),
        .dev_oe(perr_oe), .pin_n(line_n));

    always #5 ref_clk = ~ref_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [7:0] eff_of(input logic [7:0] v);
        return (v inside {8'h04, 8'h08, 8'h10, 8'h20, 8'h40}) ? v : 8'h00;
    endfunction : eff_of

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic chk1(input string nm, input logic seen, input logic exp);
        check(nm, {31'h0, seen}, {31'h0, exp});
    endtask : chk1

    // One access; done and data one edge later
    task automatic access(input logic we, input logic [7:0] a,
                          input logic [3:0] be, input logic [31:0] wd);
        @(negedge ref_clk);
        req = '{sel: 1'b1, we: we, addr: a, be: be, wdata: wd};
        @(negedge ref_clk);
        req.sel = 1'b0;
        chk1("cfg_done", done, 1'b1);
        rd = rdata;
    endtask : access

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 4'h0, 32'h0);
        check("read data", rd, exp);
    endtask : rd_chk

    // Command word write mirrored in the bench model
    task automatic wr_cs(input logic [3:0] be, input logic [31:0] wd);
        access(1'b1, 8'h04, be, wd);
        if (be[0]) cmd_m[6:0] = wd[6:0] & 7'h46;
        if (be[1]) cmd_m[8] = wd[8];
        if (be[3]) flg_m = flg_m & ~(wd & 32'hF100_0000);
    endtask : wr_cs

    task automatic fire(input pcs_pkg::pcs_evt_t e);
        @(negedge ref_clk);
        evt = e;
        @(negedge ref_clk);
        evt = '0;
    endtask : fire

    // Address phase, then medium-timed select and release
    task automatic claim_try(input logic io, input logic exp_o);
        @(negedge ref_clk);
        {ap, mhit, ihit} = {2'h3, io};
        @(negedge ref_clk);
        ap = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk1("select", ds_o, exp_o);
        xd = 1'b1;
        @(negedge ref_clk);
        xd = 1'b0;
        @(negedge ref_clk);
        chk1("select enable", ds_oe, 1'b0);
    endtask : claim_try

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict

    // Watchdog far past the test length
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        give_verdict();
    end

    initial begin
        {ref_clk, nrst, ap, mhit, ihit, xd, mreq, pull} = 8'h00;
        {req, evt, burst, cmd_m, flg_m, rd, d} = '0;
        lfsr_r = 16'h600B;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        mreq = 1'b1;
        rd_chk(8'h04, 32'h0280_0000);
        access(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
        rd_chk(8'h08, {24'h028000, REV});
        rd_chk(8'h0C, 32'h0080_0000);
        rd_chk(8'h40, 32'h0);
        // Random command writes, all-ones and all-zeros first
        for (int i = 0; i < 12; i++) begin
            lfsr_r = lfsr_next(lfsr_r);
            d = (i == 0) ? 32'hFFFF_FFFF : {lfsr_r, ~lfsr_r} & {32{i > 1}};
            wr_cs((i < 2) ? 4'hF : lfsr_r[3:0], d);
            rd_chk(8'h04, flg_m | 32'h0280_0000 | cmd_m);
            chk1("master req", mreq_o, cmd_m[2]);
            chk1("mem claim", claim, cmd_m[1]);
            chk1("parity act", pact, cmd_m[6]);
        end
        foreach (cls_tab[i]) begin
            lfsr_r = lfsr_next(lfsr_r);
            burst = cls_tab[i] + {7'h00, lfsr_r[8]};
            access(1'b1, 8'h0C, 4'hF, {16'hFFFF, lfsr_r[7:0], cls_tab[i]});
            rd_chk(8'h0C, {16'h0080, lfsr_r[7:0], cls_tab[i]});
            check("line", {24'h0, cls_eff}, {24'h0, eff_of(cls_tab[i])});
            chk1("multiple", urm, burst > eff_of(cls_tab[i]));
            check("latency", {24'h0, lat}, {24'h0, lfsr_r[7:0]});
        end
        // Events with every enable off, then on
        wr_cs(4'h3, 32'h0);
        fire(7'h08);
        chk1("serr enable", serr_oe, 1'b0);
        fire(7'h04);
        fire(7'h30);
        fire(7'h40);
        flg_m = 32'hD000_0000;
        rd_chk(8'h04, flg_m | 32'h0280_0000);
        wr_cs(4'h3, 32'h0000_0146);
        fire(7'h20);
        fire(7'h06);
        @(negedge ref_clk);
        evt = 7'h08;
        @(negedge ref_clk);
        chk1("serr pin", serr_oe & ~serr_o, 1'b1);
        evt = '0;
        flg_m = 32'hF100_0000;
        rd_chk(8'h04, flg_m | 32'h0280_0146);
        wr_cs(4'h8, 32'hF100_0000);
        rd_chk(8'h04, 32'h0280_0146);
        // Other agent pulls the parity line while mastering
        @(negedge ref_clk);
        {evt, pull} = {7'h02, 1'b1};
        repeat (6) @(negedge ref_clk);
        {evt, pull} = '0;
        flg_m = 32'h8100_0000;
        rd_chk(8'h04, flg_m | 32'h0280_0146);
        wr_cs(4'h8, 32'h8000_0000);
        wr_cs(4'h7, 32'hFFFF_FFFF);
        rd_chk(8'h04, flg_m | 32'h0280_0146);
        // Abort event lands on the same edge as its clear
        fork
            wr_cs(4'h8, 32'h1000_0000);
            fire(7'h40);
        join
        flg_m[28] = 1'b1;
        rd_chk(8'h04, flg_m | 32'h0280_0146);
        @(negedge ref_clk);
        evt = 7'h03;
        repeat (2) @(negedge ref_clk);
        chk1("parity line", line_n, 1'b0);
        evt = '0;
        claim_try(1'b0, 1'b0);
        claim_try(1'b1, 1'b1);
        wr_cs(4'h3, 32'h0);
        claim_try(1'b0, 1'b1);
        // Second reset in mid-run clears the writable fields
        wr_cs(4'h3, 32'h0000_0146);
        access(1'b1, 8'h0C, 4'h3, 32'h0000_3310);
        @(negedge ref_clk);
        nrst = 1'b0;
        @(negedge ref_clk);
        nrst = 1'b1;
        chk1("master req", mreq_o, 1'b0);
        rd_chk(8'h04, 32'h0280_0000);
        rd_chk(8'h0C, 32'h0080_0000);
        give_verdict();
    end
endmodule : pcs_config_regs_tb_top
